// ### cisov_consts.vh
/*
 * constants for the configuration-time optional pin controller:
 * register offsets, field positions, reset values, state codes.
 * assumes inclusion by bare name from the design file and the bench.
 */
`ifndef CISOV_CONSTS_VH
`define CISOV_CONSTS_VH

// ********************
// register byte offsets
// ********************
`define CISOV_ADDR_CTRL 4'h0
`define CISOV_ADDR_STAT 4'h4
`define CISOV_ADDR_IRQ 4'h8
`define CISOV_ADDR_MASK 4'hC

// ********************
// control register fields
// ********************
`define CISOV_CTRL_CLKUSE 0
`define CISOV_CTRL_DONE 1
`define CISOV_CTRL_OE 2
`define CISOV_CTRL_CLR 3
`define CISOV_CTRL_W 4
`define CISOV_CTRL_RST 4'h0

// ********************
// status and event fields
// ********************
`define CISOV_EV_FRAME 0
`define CISOV_EV_USER 1
`define CISOV_EV_RESTART 2
`define CISOV_EV_W 3
`define CISOV_EV_ZERO 3'h0

// ********************
// axi responses
// ********************
`define CISOV_RESP_OK 2'h0
`define CISOV_RESP_SLVERR 2'h2

// ********************
// sequencer states, one-hot
// ********************
`define CISOV_ST_IDLE 4'h1
`define CISOV_ST_LOAD 4'h2
`define CISOV_ST_INIT 4'h4
`define CISOV_ST_USER 4'h8

`endif

// ### cisov_top.v
/*
 * optional configuration pin controller: start-up clock pacing, open-drain
 * init-done, device-wide output enable and register clear overrides.
 * assumes a configuration engine that flags the first data frame, and
 * software on an axi4-lite port; pins come in asynchronous.
 */
// Chosen here: the placing of the registers and register access over AXI4-Lite.
// Function
// [RULE1] a disabled optional pin behaves as an ordinary user pin.
// [RULE2] during configuration a disabled optional pin is tri-stated with weak pull-up.
// [RULE3] with the start-up clock option on, initialization steps on that clock's edges.
// [RULE4] init-done is undriven while config request is low and early in configuration.
// [RULE5] once the init-done enable bit arrives in the first frame, init-done drives low.
// [RULE6] at end of initialization init-done is released and user mode is entered.
// [RULE7] the monitor outside treats a rising init-done as entry into user mode.
// [RULE8] an enabled output-enable override held low tri-states every user pin; the code forces only pin_oe_o off, not opt_pin_oe_o.
// [RULE9] the output-enable override high leaves pins at their programmed enables.
// [RULE10] an enabled clear override held low forces every register clear.
// [RULE11] the clear override high leaves registers at programmed clear and load.
// [RULE12] the outside keeps test port pins steady before and during configuration.
// [RULE13] init-done only drives low or floats, never drives high.
`timescale 1ns/100ps
`include "cisov_consts.vh"

module cisov_top #(
  parameter INIT_STEPS = 8,
  parameter NPINS = 4
) (
  input wire mclk_i, // system clock
  input wire rst_i, // synchronous reset, high
  input wire config_request_n_i, // configuration request pin, low restarts
  input wire first_frame_i, // pulse: first configuration frame taken
  input wire frame_done_en_i, // init-done enable bit of that frame
  input wire load_done_i, // pulse: configuration data complete
  input wire startup_clock_in_i, // user start-up clock pin
  input wire global_output_enable_n_i, // device-wide output enable pin
  input wire global_register_clear_n_i, // device-wide clear pin
  input wire [NPINS-1:0] user_oe_i, // programmed user pin enables
  input wire [NPINS-1:0] user_out_i, // user pin output data
  output reg [NPINS-1:0] pin_oe_o, // final user pin enables
  output reg [NPINS-1:0] pin_out_o, // final user pin data
  output reg [3:0] opt_pin_oe_o, // optional pins as user i/o enables
  output reg [3:0] opt_pin_pullup_o, // weak pull-up on optional pins
  output reg init_done_out_o, // init-done drive value, always 0
  output reg init_done_oe_o, // init-done drive enable
  output reg user_mode_o, // device in user mode
  output reg global_clear_o, // clear all user registers
  output reg irq_o, // level interrupt
  input wire [3:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [3:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read valid
  input wire s_axi_rready // read ready
);

  // ********************
  // pin synchronisers
  // ********************
  reg [2:0] cfg_sync;
  reg [2:0] suc_sync;
  reg [2:0] oe_sync;
  reg [2:0] clr_sync;
  reg cfg_n;
  reg suc_lvl;
  reg suc_prev;
  reg oe_n;
  reg clr_n;

  // a change counts only once stages two and three agree
  function filt;
    input [2:0] s;
    input cur;
    begin
      filt = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  always @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_sync <= 3'h0;
      suc_sync <= 3'h0;
      // override pins idle high: no false override right after reset
      oe_sync <= 3'h7;
      clr_sync <= 3'h7;
      cfg_n <= 1'b0;
      suc_lvl <= 1'b0;
      suc_prev <= 1'b0;
      oe_n <= 1'b1;
      clr_n <= 1'b1;
    end else begin
      cfg_sync <= {cfg_sync[1:0], config_request_n_i};
      suc_sync <= {suc_sync[1:0], startup_clock_in_i};
      oe_sync <= {oe_sync[1:0], global_output_enable_n_i};
      clr_sync <= {clr_sync[1:0], global_register_clear_n_i};
      cfg_n <= filt(cfg_sync, cfg_n);
      suc_lvl <= filt(suc_sync, suc_lvl);
      suc_prev <= suc_lvl;
      oe_n <= filt(oe_sync, oe_n);
      clr_n <= filt(clr_sync, clr_n);
    end
  end

  // ********************
  // registers
  // ********************
  reg [`CISOV_CTRL_W-1:0] ctrl;
  reg [`CISOV_EV_W-1:0] irq_stat;
  reg [`CISOV_EV_W-1:0] irq_mask;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [7:0] step_cnt;
  reg done_en;

  // ********************
  // sequencer states
  // ********************
  localparam [3:0] ST_IDLE = `CISOV_ST_IDLE;
  localparam [3:0] ST_LOAD = `CISOV_ST_LOAD;
  localparam [3:0] ST_INIT = `CISOV_ST_INIT;
  localparam [3:0] ST_USER = `CISOV_ST_USER;
  // full-word compares, so a corrupted code never reads as a live state
  wire in_load = (state == ST_LOAD);
  wire in_init = (state == ST_INIT);
  wire in_user = (state == ST_USER);

  wire use_suc = ctrl[`CISOV_CTRL_CLKUSE];
  wire use_done = ctrl[`CISOV_CTRL_DONE];
  wire use_oe = ctrl[`CISOV_CTRL_OE];
  wire use_clr = ctrl[`CISOV_CTRL_CLR];
  wire configuring = ~in_user;
  // with the option off the step ticks every clock
  wire step = use_suc ? (suc_lvl & ~suc_prev) : 1'b1; // RULE3
  wire init_end = in_init & step & (step_cnt == INIT_STEPS - 1);

  // ********************
  // initialization sequencer
  // ********************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cfg_n) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (load_done_i) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_end) begin
          next_state = ST_USER; // RULE6
        end
      end
      ST_USER: begin
        next_state = ST_USER;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!cfg_n) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      step_cnt <= 8'h00;
      done_en <= 1'b0;
    end else begin
      state <= next_state;
      if (!in_init) begin
        step_cnt <= 8'h00;
      end else if (step) begin
        step_cnt <= step_cnt + 8'h01; // RULE3
      end
      if (!cfg_n) begin
        done_en <= 1'b0; // RULE4
      end else if (in_load && first_frame_i) begin
        done_en <= frame_done_en_i; // RULE5
      end
    end
  end

  // ********************
  // pin outputs
  // ********************
  integer i;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_oe_o <= {NPINS{1'b0}};
      pin_out_o <= {NPINS{1'b0}};
      opt_pin_oe_o <= 4'h0;
      opt_pin_pullup_o <= 4'hF;
      init_done_out_o <= 1'b0;
      init_done_oe_o <= 1'b0;
      user_mode_o <= 1'b0;
      global_clear_o <= 1'b0;
    end else begin
      user_mode_o <= in_user; // RULE6
      // user pins stay off while configuring; override forces them off
      for (i = 0; i < NPINS; i = i + 1) begin
        if (configuring || (use_oe && !oe_n)) begin
          pin_oe_o[i] <= 1'b0; // RULE8
        end else begin
          pin_oe_o[i] <= user_oe_i[i]; // RULE9
        end
      end
      pin_out_o <= user_out_i;
      // a disabled optional pin is a plain user pin: tri-stated with pull-up
      // while configuring, then as programmed
      opt_pin_pullup_o <= configuring ? ~ctrl : 4'h0; // RULE2
      opt_pin_oe_o <= configuring ? 4'h0 : ~ctrl; // RULE1
      init_done_out_o <= 1'b0; // RULE13
      // low from the enabling frame until init ends, then floats high
      init_done_oe_o <= use_done & done_en & (in_load | in_init) & ~init_end; // RULE5
      // the clear override only acts while its option bit is set
      if (use_clr && !clr_n) begin
        global_clear_o <= 1'b1; // RULE10
      end else begin
        global_clear_o <= 1'b0; // RULE11
      end
    end
  end

  // ********************
  // axi4-lite slave
  // ********************
  reg [3:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  reg [`CISOV_EV_W-1:0] ev;
  reg [`CISOV_EV_W-1:0] w1c;
  // one write in flight: a new pair waits until the response is taken
  wire do_wr = aw_have & w_have & ~s_axi_bvalid;

  always @* begin
    ev = `CISOV_EV_ZERO;
    ev[`CISOV_EV_FRAME] = in_load & first_frame_i;
    ev[`CISOV_EV_USER] = init_end;
    // restart: request seen released while still configuring
    ev[`CISOV_EV_RESTART] = configuring & cfg_sync[2] & ~cfg_n;
    w1c = `CISOV_EV_ZERO;
    if (do_wr && aw_addr == `CISOV_ADDR_IRQ && w_strb[0]) begin
      w1c = w_data[`CISOV_EV_W-1:0];
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CISOV_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CISOV_RESP_OK;
      s_axi_rdata <= 32'h0;
      aw_addr <= 4'h0;
      aw_have <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      w_have <= 1'b0;
      ctrl <= `CISOV_CTRL_RST;
      irq_stat <= `CISOV_EV_ZERO;
      irq_mask <= `CISOV_EV_ZERO;
      irq_o <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
      end
      s_axi_wready <= ~w_have & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
      end
      if (do_wr) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CISOV_RESP_OK;
        case (aw_addr)
          `CISOV_ADDR_CTRL: begin
            // option bits are taken only while not configuring
            if (w_strb[0] && !configuring) begin
              ctrl <= w_data[`CISOV_CTRL_W-1:0];
            end
          end
          `CISOV_ADDR_MASK: begin
            if (w_strb[0]) begin
              irq_mask <= w_data[`CISOV_EV_W-1:0];
            end
          end
          `CISOV_ADDR_IRQ: begin
            s_axi_bresp <= `CISOV_RESP_OK;
          end
          default: begin
            s_axi_bresp <= `CISOV_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // set wins over a same-cycle clear
      irq_stat <= (irq_stat & ~w1c) | ev;
      irq_o <= |(((irq_stat & ~w1c) | ev) & irq_mask);
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CISOV_RESP_OK;
        s_axi_rdata <= 32'h0;
        case (s_axi_araddr)
          `CISOV_ADDR_CTRL: s_axi_rdata[`CISOV_CTRL_W-1:0] <= ctrl;
          `CISOV_ADDR_STAT: s_axi_rdata[7:0] <= {oe_n, clr_n, done_en, cfg_n, state};
          `CISOV_ADDR_IRQ: s_axi_rdata[`CISOV_EV_W-1:0] <= irq_stat;
          `CISOV_ADDR_MASK: s_axi_rdata[`CISOV_EV_W-1:0] <= irq_mask;
          default: s_axi_rresp <= `CISOV_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ### cisov_chk.sv
/* assertions for the optional pin controller, bound to cisov_top.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module cisov_chk #(parameter NPINS = 4) (
  input wire mclk_i, // clock
  input wire rst_i, // reset
  input wire config_request_n_i, // request pin
  input wire first_frame_i, // frame pulse
  input wire frame_done_en_i, // enable bit
  input wire global_output_enable_n_i, // oe pin
  input wire global_register_clear_n_i, // clear pin
  input wire [NPINS-1:0] user_oe_i, // enables in
  input wire [NPINS-1:0] pin_oe_o, // enables out
  input wire [3:0] opt_pin_oe_o, // option enables
  input wire [3:0] opt_pin_pullup_o, // pull-ups
  input wire init_done_out_o, // done value
  input wire init_done_oe_o, // done enable
  input wire user_mode_o, // user mode
  input wire global_clear_o // clear all
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_done_open_drain: assert property (init_done_oe_o |->
    !init_done_out_o && !user_mode_o)
    else $error("init-done driven high");
  a_done_low_cause: assert property ($rose(init_done_oe_o) |->
    $past(first_frame_i && frame_done_en_i, 2))
    else $error("init-done low without enable frame");
  a_done_float_req: assert property ((!config_request_n_i) [*8] |->
    !init_done_oe_o && !user_mode_o)
    else $error("init-done driven while request low");
  a_user_releases: assert property ($rose(user_mode_o) |-> !init_done_oe_o)
    else $error("user mode with init-done low");
  a_opt_cfg_float: assert property (!user_mode_o && !$past(user_mode_o) |->
    opt_pin_oe_o == 4'h0)
    else $error("optional pin driven in config");
  a_opt_user_io: assert property (user_mode_o && $past(user_mode_o) |->
    opt_pin_pullup_o == 4'h0)
    else $error("pull-up left on in user mode");
  a_oe_follows: assert property (
    (user_mode_o && global_output_enable_n_i && config_request_n_i) [*8]
    |-> pin_oe_o == $past(user_oe_i))
    else $error("enables not as programmed");
  a_clear_idle: assert property (global_register_clear_n_i [*8] |-> !global_clear_o)
    else $error("clear with pin high");
endmodule
bind cisov_top cisov_chk #(.NPINS(NPINS)) chk (.mclk_i, .rst_i, .config_request_n_i,
  .first_frame_i, .frame_done_en_i, .global_output_enable_n_i, .global_register_clear_n_i,
  .user_oe_i, .pin_oe_o, .opt_pin_oe_o, .opt_pin_pullup_o, .init_done_out_o,
  .init_done_oe_o, .user_mode_o, .global_clear_o);

// ### cisov_host.sv
/* configuration host and init-done monitor facing the device.
   assumes an external pull-up on init-done; start-up clock still unless ticked. */
`timescale 1ns/100ps
module cisov_host (
  input wire mclk_i, // clock
  input wire init_done_out_i, // done value
  input wire init_done_oe_i, // done enable
  output reg config_request_n_o, // low restarts
  output reg first_frame_o, // frame pulse
  output reg frame_done_en_o, // enable bit
  output reg load_done_o, // data complete
  output reg startup_clock_o, // start-up clock
  output reg [7:0] rise_cnt_o // rising edges seen
);
  // released line reads high through the pull-up
  wire done_line = init_done_oe_i ? init_done_out_i : 1'b1;
  reg done_q = 1'b1;
  initial begin
    {config_request_n_o, first_frame_o, frame_done_en_o, load_done_o} = 4'h0;
    startup_clock_o = 1'b0;
    rise_cnt_o = 8'h0;
  end
  always @(posedge mclk_i) begin
    done_q <= done_line;
    if (done_line && !done_q) rise_cnt_o <= rise_cnt_o + 8'h1;
  end
  // the host never touches the test-port lines around a restart
  task restart; begin
    @(posedge mclk_i) config_request_n_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    config_request_n_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
  end endtask
  task load(input en); begin
    @(posedge mclk_i) first_frame_o <= 1'b1;
    frame_done_en_o <= en;
    @(posedge mclk_i) first_frame_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    load_done_o <= 1'b1;
    @(posedge mclk_i) load_done_o <= 1'b0;
  end endtask
  task tick(input integer n); repeat (n) begin
    repeat (3) @(posedge mclk_i);
    startup_clock_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    startup_clock_o <= 1'b0;
  end endtask
endmodule

// ### tb_cisov.sv
/* self-checking bench for cisov_top with the host model.
   assumes the design's constants header and four init steps. */
`timescale 1ns/100ps
`include "cisov_consts.vh"
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb;
  logic mclk_i, rst_i, config_request_n_i, first_frame_i, frame_done_en_i, load_done_i;
  logic startup_clock_in_i, global_output_enable_n_i, global_register_clear_n_i;
  logic [3:0] user_oe_i, user_out_i, pin_oe_o, pin_out_o, opt_pin_oe_o, opt_pin_pullup_o;
  logic init_done_out_o, init_done_oe_o, user_mode_o, global_clear_o, irq_o;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] rise_cnt;
  integer err_count = 0, checks = 0, w;
  cisov_top #(.INIT_STEPS(4)) uut (.mclk_i, .rst_i, .config_request_n_i, .first_frame_i,
    .frame_done_en_i, .load_done_i, .startup_clock_in_i, .global_output_enable_n_i,
    .global_register_clear_n_i, .user_oe_i, .user_out_i, .pin_oe_o, .pin_out_o, .opt_pin_oe_o,
    .opt_pin_pullup_o, .init_done_out_o, .init_done_oe_o, .user_mode_o, .global_clear_o, .irq_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cisov_host host (.mclk_i, .init_done_out_i(init_done_out_o), .init_done_oe_i(init_done_oe_o),
    .config_request_n_o(config_request_n_i), .first_frame_o(first_frame_i),
    .frame_done_en_o(frame_done_en_i), .load_done_o(load_done_i),
    .startup_clock_o(startup_clock_in_i), .rise_cnt_o(rise_cnt));
  // ********
  // bus and helpers
  // ********
  task complete_run;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task bus(input wr, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge mclk_i);
      if (wr) begin
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      end else begin
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
      end
      for (n = 0; n < 50; n++) begin
        @(posedge mclk_i);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_bvalid || s_axi_rvalid) begin
          q = s_axi_rdata;
          r = wr ? s_axi_bresp : s_axi_rresp;
          {s_axi_bready, s_axi_rready} <= 2'h0;
          n = 99;
        end
      end
      if (n == 50) begin err_count++; complete_run; end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    bus(1'b1, a, d);
    `CHK(r, `CISOV_RESP_OK, "write response")
  endtask
  task rd(input [3:0] a, input [31:0] e, input [1:0] er);
    bus(1'b0, a, 32'h0);
    `CHK(r, er, "read response")
    `CHK(q, e, "read data")
  endtask
  task pins(input v);
    @(posedge mclk_i) global_output_enable_n_i <= v;
    global_register_clear_n_i <= v;
    repeat (8) @(negedge mclk_i);
  endtask
  // ********
  // scenarios
  // ********
  task s_plain; // first load with every option still off
    @(negedge mclk_i);
    `CHK(opt_pin_pullup_o, 4'hF, "no pull-up in config")
    host.restart;
    host.load(1'b1);
    for (w = 0; w < 200 && user_mode_o !== 1'b1; w++) @(negedge mclk_i);
    `CHK(user_mode_o, 1'b1, "no user mode")
    if (w == 200) complete_run;
    `CHK(opt_pin_oe_o, 4'hF, "option pins not i/o")
    `CHK(rise_cnt, 8'h0, "init-done used while off")
    rd(`CISOV_ADDR_CTRL, 32'h0, `CISOV_RESP_OK);
    rd(`CISOV_ADDR_STAT, 32'hF8, `CISOV_RESP_OK);
    rd(4'h2, 32'h0, `CISOV_RESP_SLVERR);
  endtask
  task s_init; // options on, steps paced by the start-up clock
    wr(`CISOV_ADDR_CTRL, 32'hF);
    rd(`CISOV_ADDR_CTRL, 32'hF, `CISOV_RESP_OK);
    host.restart;
    @(negedge mclk_i);
    `CHK(init_done_oe_o, 1'b0, "init-done driven early")
    `CHK(opt_pin_pullup_o, 4'h0, "pull-up on enabled pin")
    wr(`CISOV_ADDR_CTRL, 32'h0);
    rd(`CISOV_ADDR_CTRL, 32'hF, `CISOV_RESP_OK);
    host.load(1'b1);
    repeat (2) @(negedge mclk_i);
    `CHK(init_done_oe_o, 1'b1, "init-done not low")
    `CHK(init_done_out_o, 1'b0, "init-done driven high")
    repeat (20) @(negedge mclk_i);
    `CHK(user_mode_o, 1'b0, "init ran with clock still")
    host.tick(3);
    `CHK(user_mode_o, 1'b0, "too few steps")
    host.tick(1);
    repeat (4) @(negedge mclk_i);
    `CHK(user_mode_o, 1'b1, "no user mode")
    `CHK(init_done_oe_o, 1'b0, "init-done not released")
    `CHK(rise_cnt, 8'h1, "no rising init-done")
  endtask
  task s_ovr; // overrides enabled, then disabled
    @(posedge mclk_i) user_oe_i <= 4'hF;
    user_out_i <= 4'hA;
    repeat (8) @(negedge mclk_i);
    `CHK(pin_oe_o, 4'hF, "enables not followed")
    `CHK(pin_out_o, 4'hA, "data not followed")
    pins(1'b0);
    `CHK(pin_oe_o, 4'h0, "pins not tri-stated")
    `CHK(global_clear_o, 1'b1, "no clear")
    pins(1'b1);
    `CHK(pin_oe_o, 4'hF, "enables not restored")
    `CHK(global_clear_o, 1'b0, "clear stuck")
    wr(`CISOV_ADDR_CTRL, 32'h3);
    pins(1'b0);
    `CHK(pin_oe_o, 4'hF, "disabled override acted")
    `CHK(global_clear_o, 1'b0, "disabled clear acted")
    pins(1'b1);
  endtask
  task s_irq; // sticky events, mask and write-one clear
    rd(`CISOV_ADDR_IRQ, 32'h7, `CISOV_RESP_OK);
    `CHK(irq_o, 1'b0, "irq while masked")
    wr(`CISOV_ADDR_MASK, 32'h2);
    repeat (2) @(negedge mclk_i);
    `CHK(irq_o, 1'b1, "irq missing")
    wr(`CISOV_ADDR_IRQ, 32'h2);
    repeat (2) @(negedge mclk_i);
    `CHK(irq_o, 1'b0, "irq not cleared")
    rd(`CISOV_ADDR_IRQ, 32'h5, `CISOV_RESP_OK);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    {rst_i, global_output_enable_n_i, global_register_clear_n_i} = 3'h7;
    {user_oe_i, user_out_i, s_axi_awaddr, s_axi_araddr} = 16'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    s_plain;
    s_init;
    s_ovr;
    s_irq;
    complete_run;
  end
endmodule
